// File: input_cfg_pkg.sv
// Constants for the input configuration and secondary fault register bank
package input_cfg_pkg;

   // ************************************************************
   // Register offsets, as seen on the serial register port
   // ************************************************************
   localparam logic [7:0] ADDR_GENERAL_CONFIG          = 8'h18;
   localparam logic [7:0] ADDR_CHANNEL_ENABLE          = 8'h1a;
   localparam logic [7:0] ADDR_SECONDARY_FAULT_STATUS  = 8'h1c;
   localparam logic [7:0] ADDR_SECONDARY_FAULT_ENABLE  = 8'h1e;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_GENERAL_CONFIG           = 8'h00;
   localparam logic [7:0] RST_CHANNEL_ENABLE           = 8'hff;
   localparam logic [7:0] RST_SECONDARY_FAULT_STATUS   = 8'h02;
   localparam logic [7:0] RST_SECONDARY_FAULT_ENABLE   = 8'h00;

   // ************************************************************
   // Writable-bit masks; reserved bits read zero
   // ************************************************************
   localparam logic [7:0] MASK_GENERAL_CONFIG          = 8'h19;
   localparam logic [7:0] MASK_CHANNEL_ENABLE          = 8'hff;
   localparam logic [7:0] MASK_SECONDARY_FAULT         = 8'h3f;

   // ************************************************************
   // General configuration field positions
   // ************************************************************
   localparam int CFG_INPUT_REF_SHORT_DETECT_ENABLE    = 0;
   localparam int CFG_FILTER_FREEZE                    = 3;
   localparam int CFG_SUPPLY_FLAG_CLEAR_MODE           = 4;

   // ************************************************************
   // Secondary fault status / enable field positions
   // ************************************************************
   localparam int F2_WIREBREAK_REF_SHORT               = 0;
   localparam int F2_WIREBREAK_REF_OPEN                = 1;
   localparam int F2_INPUT_REF_SHORT                   = 2;
   localparam int F2_INPUT_REF_OPEN                    = 3;
   localparam int F2_OVERTEMP_SHUTDOWN                 = 4;
   localparam int F2_CLOCK_COUNT_ERROR                 = 5;

   // ************************************************************
   // Serial interface modes in which the clear-mode bit matters
   // ************************************************************
   localparam logic [1:0] SPI_MODE_0                   = 2'h0;
   localparam logic [1:0] SPI_MODE_2                   = 2'h2;

endpackage

// File: level_sync.sv
// Two-flop synchroniser for a vector of independent asynchronous levels
`timescale 1ns/1ns
module level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset,
   // Asynchronous levels in
   input  wire logic [WIDTH-1:0] async_in,
   // Synchronised levels out
   output logic      [WIDTH-1:0] sync_out
);

   // ************************************************************
   // Synchroniser stages
   // ************************************************************
   logic [WIDTH-1:0] meta_r;     // First stage, read only by second stage
   logic [WIDTH-1:0] meta_nxt;   // Next value of first stage
   logic [WIDTH-1:0] stable_r;   // Second stage, safe for logic
   logic [WIDTH-1:0] stable_nxt; // Next value of second stage

   // Next-state: plain shift; bits are independent levels, not a word
   always_comb begin
      meta_nxt   = async_in;
      stable_nxt = meta_r;
   end

   // Registers, cleared synchronously so no stale fault shows after reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_r   <= '0;
         stable_r <= '0;
      end else begin
         meta_r   <= meta_nxt;
         stable_r <= stable_nxt;
      end
   end

   assign sync_out = stable_r;

endmodule

// File: input_cfg_regs.sv
// Configuration, channel-enable and secondary fault registers of the input device
`timescale 1ns/1ns
module input_cfg_regs #(
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset,
   // Register port from the serial frame decoder
   input  wire logic                reg_wr_stb,
   input  wire logic                reg_rd_stb,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   output logic      [7:0]          reg_rdata,
   // Frame events from the serial frame decoder
   input  wire logic                frame_done,
   input  wire logic                frame_clk_count_bad,
   input  wire logic                primary_fault_read,
   input  wire logic [1:0]          spi_mode,
   input  wire logic                wirebreak_any_enabled,
   // Analog fault detectors, asynchronous levels
   input  wire logic                supply_low_det,
   input  wire logic                supply_missing_det,
   input  wire logic                overtemp_det,
   input  wire logic                input_ref_open_det,
   input  wire logic                input_ref_short_det,
   input  wire logic                wirebreak_ref_open_det,
   input  wire logic                wirebreak_ref_short_det,
   // Filtered input states from the channel filters
   input  wire logic [CHANNELS-1:0] filtered_state,
   // Controls to the field side
   output logic [CHANNELS-1:0]      input_enable,
   output logic [CHANNELS-1:0]      current_source_on,
   output logic                     led_drivers_off,
   output logic                     filter_freeze,
   output logic                     input_ref_short_detect_enable,
   // Status toward the primary fault register and input state register
   output logic [CHANNELS-1:0]      input_state_register,
   output logic                     supply_low_flag,
   output logic                     supply_missing_flag,
   output logic                     secondary_fault_summary
);

   // ************************************************************
   // Decode helper
   // ************************************************************

   // Access of a given kind hits a given register offset
   function automatic logic reg_hit(input logic stb, input logic [7:0] addr,
                                    input logic [7:0] offset);
      reg_hit = stb && (addr == offset);
   endfunction

   // ************************************************************
   // Detector synchronisation
   // ************************************************************
   logic [6:0] det_sync;   // Synchronised detector levels

   level_sync #(
      .WIDTH(7)
   ) u_det_sync (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in ({supply_low_det, supply_missing_det, overtemp_det,
                  input_ref_open_det, input_ref_short_det,
                  wirebreak_ref_open_det, wirebreak_ref_short_det}),
      .sync_out (det_sync)
   );

   logic low_s;       // Supply below low threshold
   logic miss_s;      // Supply below missing threshold
   logic ot_s;        // Overtemperature shutdown active
   logic iref_open_s; // Input reference pin open
   logic iref_shrt_s; // Input reference pin shorted
   logic wref_open_s; // Wire-break reference pin open
   logic wref_shrt_s; // Wire-break reference pin shorted

   assign {low_s, miss_s, ot_s, iref_open_s, iref_shrt_s, wref_open_s, wref_shrt_s} = det_sync;

   // ************************************************************
   // Register state
   // ************************************************************
   logic [7:0]          cfg_r,     cfg_nxt;     // General configuration
   logic [7:0]          chen_r,    chen_nxt;    // Channel enables
   logic [7:0]          f2_r,      f2_nxt;      // Secondary fault status
   logic [7:0]          f2en_r,    f2en_nxt;    // Secondary fault enables
   logic                low_r,     low_nxt;     // Supply-low latch
   logic                miss_r,    miss_nxt;    // Supply-missing latch
   logic                sum_r,     sum_nxt;     // Summary bit
   logic [7:0]          rdata_r,   rdata_nxt;   // Read data
   logic [CHANNELS-1:0] channel_enable_r,    channel_enable_nxt;    // Effective input enables
   logic [CHANNELS-1:0] state_r,   state_nxt;   // Gated input states
   logic                ledoff_r,  ledoff_nxt;  // LED drivers forced off

   logic                wr_ok;        // Write not rejected by the frame checker
   logic                supply_clr;   // Clear event for supply flags
   logic                mode_honours; // Clear-mode bit is in force
   logic [7:0]          f2_set;       // Hardware set terms
   logic [7:0]          f2_rd_clr;    // Read clear terms
   logic                short_kill;   // Qualified input-reference short

   // ************************************************************
   // Next-state logic
   // ************************************************************

   // Computes every register's next value; set always beats clear
   always_comb begin
      // A malformed frame carries no command, so its write is dropped
      wr_ok = reg_wr_stb && !frame_clk_count_bad;

      cfg_nxt  = cfg_r;
      chen_nxt = chen_r;
      f2en_nxt = f2en_r;
      // Reserved bits are masked on write so they always read zero
      if (reg_hit(wr_ok, reg_addr, input_cfg_pkg::ADDR_GENERAL_CONFIG)) begin
         cfg_nxt = reg_wdata & input_cfg_pkg::MASK_GENERAL_CONFIG;
      end
      if (reg_hit(wr_ok, reg_addr, input_cfg_pkg::ADDR_CHANNEL_ENABLE)) begin
         chen_nxt = reg_wdata & input_cfg_pkg::MASK_CHANNEL_ENABLE;
      end
      if (reg_hit(wr_ok, reg_addr, input_cfg_pkg::ADDR_SECONDARY_FAULT_ENABLE)) begin
         f2en_nxt = reg_wdata & input_cfg_pkg::MASK_SECONDARY_FAULT;
      end

      // Clear-mode bit only counts in interface modes 0 and 2
      mode_honours = (spi_mode == input_cfg_pkg::SPI_MODE_0) ||
                     (spi_mode == input_cfg_pkg::SPI_MODE_2);
      // Mode 1 of the bit, or any other interface mode: read only
      supply_clr = primary_fault_read;
      if (mode_honours && !cfg_r[input_cfg_pkg::CFG_SUPPLY_FLAG_CLEAR_MODE]) begin
         supply_clr = primary_fault_read || frame_done;
      end
      // Live condition re-sets the latch, so a clear under fault is lost
      low_nxt  = low_s  || (low_r  && !supply_clr);
      miss_nxt = miss_s || (miss_r && !supply_clr);

      // Short detect honoured only while enabled; 1 enables
      short_kill = iref_shrt_s && cfg_r[input_cfg_pkg::CFG_INPUT_REF_SHORT_DETECT_ENABLE];

      // Hardware set terms per flag
      f2_set = 8'h00;
      f2_set[input_cfg_pkg::F2_CLOCK_COUNT_ERROR]   = reg_wr_stb && frame_clk_count_bad;
      f2_set[input_cfg_pkg::F2_OVERTEMP_SHUTDOWN]   = ot_s;
      f2_set[input_cfg_pkg::F2_INPUT_REF_OPEN]      = iref_open_s || ot_s;
      f2_set[input_cfg_pkg::F2_INPUT_REF_SHORT]     = short_kill;
      // With no wire-break function on, the reference is unused
      f2_set[input_cfg_pkg::F2_WIREBREAK_REF_OPEN]  = wref_open_s || ot_s ||
                                                      !wirebreak_any_enabled;
      f2_set[input_cfg_pkg::F2_WIREBREAK_REF_SHORT] = wref_shrt_s;
      // Any complete frame with a bad clock count flags it, read or write
      if (frame_done && frame_clk_count_bad) begin
         f2_set[input_cfg_pkg::F2_CLOCK_COUNT_ERROR] = 1'b1;
      end

      // Reading the status register clears every flag not being set
      f2_rd_clr = {8{reg_hit(reg_rd_stb, reg_addr,
                             input_cfg_pkg::ADDR_SECONDARY_FAULT_STATUS)}};
      f2_nxt = (f2_set | (f2_r & ~f2_rd_clr)) & input_cfg_pkg::MASK_SECONDARY_FAULT;

      // Summary stays up while an enabled flag stands; read cannot drop it
      sum_nxt = (|(f2_nxt & f2en_nxt)) || (sum_r && !primary_fault_read);

      // Read data; unmapped or reserved reads return zero
      rdata_nxt = rdata_r;
      if (reg_rd_stb) begin
         case (reg_addr)
            input_cfg_pkg::ADDR_GENERAL_CONFIG: begin
               rdata_nxt = cfg_r;
            end
            input_cfg_pkg::ADDR_CHANNEL_ENABLE: begin
               rdata_nxt = chen_r;
            end
            // Pre-clear value is returned, so no event is missed
            input_cfg_pkg::ADDR_SECONDARY_FAULT_STATUS: begin
               rdata_nxt = f2_r;
            end
            input_cfg_pkg::ADDR_SECONDARY_FAULT_ENABLE: begin
               rdata_nxt = f2en_r;
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end

      // Field-side gating: enable, short and shutdown all turn a channel off
      channel_enable_nxt = chen_r[CHANNELS-1:0];
      if (short_kill) begin
         channel_enable_nxt = '0;
      end
      if (ot_s) begin
         channel_enable_nxt = '0;
      end
      // Disabled channel reads as low in the input state register
      state_nxt  = filtered_state & chen_r[CHANNELS-1:0];
      ledoff_nxt = ot_s;
   end

   // ************************************************************
   // Registers
   // ************************************************************

   // Register update only; synchronous reset to documented values
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_r    <= input_cfg_pkg::RST_GENERAL_CONFIG;
         chen_r   <= input_cfg_pkg::RST_CHANNEL_ENABLE;
         f2_r     <= input_cfg_pkg::RST_SECONDARY_FAULT_STATUS;
         f2en_r   <= input_cfg_pkg::RST_SECONDARY_FAULT_ENABLE;
         low_r    <= 1'b0;
         miss_r   <= 1'b0;
         sum_r    <= 1'b0;
         rdata_r  <= 8'h00;
         channel_enable_r   <= '0;
         state_r  <= '0;
         ledoff_r <= 1'b0;
      end else begin
         cfg_r    <= cfg_nxt;
         chen_r   <= chen_nxt;
         f2_r     <= f2_nxt;
         f2en_r   <= f2en_nxt;
         low_r    <= low_nxt;
         miss_r   <= miss_nxt;
         sum_r    <= sum_nxt;
         rdata_r  <= rdata_nxt;
         channel_enable_r   <= channel_enable_nxt;
         state_r  <= state_nxt;
         ledoff_r <= ledoff_nxt;
      end
   end

   // ************************************************************
   // Outputs, all straight from flops
   // ************************************************************
   assign reg_rdata                     = rdata_r;
   assign input_enable                  = channel_enable_r;
   // Current source follows the enable; off means 0 mA
   assign current_source_on             = channel_enable_r;
   assign led_drivers_off               = ledoff_r;
   // Filters sit at mid-scale while set, resume when cleared
   assign filter_freeze                 = cfg_r[input_cfg_pkg::CFG_FILTER_FREEZE];
   assign input_ref_short_detect_enable =
      cfg_r[input_cfg_pkg::CFG_INPUT_REF_SHORT_DETECT_ENABLE];
   assign input_state_register          = state_r;
   assign supply_low_flag               = low_r;
   assign supply_missing_flag           = miss_r;
   assign secondary_fault_summary       = sum_r;

endmodule

// File: input_cfg_regs_props.sv
// Port-level assertions for the input configuration and secondary fault register bank
`timescale 1ns/1ns
module input_cfg_regs_props #(
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset,
   // Register port and frame events
   input  wire logic                reg_wr_stb,
   input  wire logic                reg_rd_stb,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic [7:0]          reg_rdata,
   input  wire logic                frame_done,
   input  wire logic                frame_clk_count_bad,
   input  wire logic                primary_fault_read,
   input  wire logic [1:0]          spi_mode,
   // Detector levels
   input  wire logic                supply_low_det,
   input  wire logic                overtemp_det,
   // Outputs under watch
   input  wire logic [CHANNELS-1:0] input_enable,
   input  wire logic [CHANNELS-1:0] current_source_on,
   input  wire logic [CHANNELS-1:0] input_state_register,
   input  wire logic                led_drivers_off,
   input  wire logic                filter_freeze,
   input  wire logic                input_ref_short_detect_enable,
   input  wire logic                supply_low_flag
);
   // ************************************************************
   // One clock domain, so clocking and reset are given once
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_unmapped_read;
      reg_rd_stb && !(reg_addr inside {8'h18, 8'h1a, 8'h1c, 8'h1e}) |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
   property p_cfg_reserved;
      reg_rd_stb && reg_addr == 8'h18 |=> (reg_rdata & 8'he6) == 8'h00;
   endproperty
   a_cfg_reserved: assert property (p_cfg_reserved) else $error("config reserved bit set");
   // Two edges allowed: the control output may be registered after the register itself
   property p_freeze;
      reg_wr_stb && !frame_clk_count_bad && reg_addr == 8'h18
         |=> ##1 filter_freeze == $past(reg_wdata[3], 2);
   endproperty
   a_freeze: assert property (p_freeze) else $error("freeze does not follow config");
   property p_short_en;
      reg_wr_stb && !frame_clk_count_bad && reg_addr == 8'h18
         |=> ##1 input_ref_short_detect_enable == $past(reg_wdata[0], 2);
   endproperty
   a_short_en: assert property (p_short_en) else $error("short detect enable wrong");
   property p_current;
      current_source_on == input_enable;
   endproperty
   a_current: assert property (p_current) else $error("current source on a disabled input");
   property p_state_gate;
      reg_wr_stb && !frame_clk_count_bad && reg_addr == 8'h1a
         |=> ##1 (input_state_register & ~$past(reg_wdata, 2)) == '0;
   endproperty
   a_state_gate: assert property (p_state_gate) else $error("disabled channel state high");
   property p_supply_set;
      supply_low_det [*4] |-> ##[0:2] supply_low_flag;
   endproperty
   a_supply_set: assert property (p_supply_set) else $error("supply low flag not set");
   property p_supply_read_clear;
      (!supply_low_det) [*4] ##0 primary_fault_read |=> !supply_low_flag;
   endproperty
   a_supply_read_clear: assert property (p_supply_read_clear) else $error("flag kept");
   // Modes 1 and 3 ignore the clear mode, so a frame alone never clears the flag there
   property p_mode_keep;
      frame_done && spi_mode[0] && !primary_fault_read && supply_low_flag |=> supply_low_flag;
   endproperty
   a_mode_keep: assert property (p_mode_keep) else $error("frame cleared flag in mode 1 or 3");
   property p_overtemp;
      overtemp_det [*4] |-> ##[0:2] (led_drivers_off && input_enable == '0);
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("overtemp did not shut inputs");
endmodule

bind input_cfg_regs input_cfg_regs_props #(.CHANNELS(CHANNELS)) u_props (
   .ref_clk(ref_clk), .reset(reset), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .frame_done(frame_done), .frame_clk_count_bad(frame_clk_count_bad),
   .primary_fault_read(primary_fault_read), .spi_mode(spi_mode),
   .supply_low_det(supply_low_det), .overtemp_det(overtemp_det),
   .input_enable(input_enable), .current_source_on(current_source_on),
   .input_state_register(input_state_register), .led_drivers_off(led_drivers_off),
   .filter_freeze(filter_freeze), .input_ref_short_detect_enable(input_ref_short_detect_enable),
   .supply_low_flag(supply_low_flag));

// File: host_model.sv
// Frame decoder stand-in that issues register accesses and frame events
`timescale 1ns/1ns
module host_model (
   // Clock
   input  wire logic       ref_clk,
   // Register port toward the bank
   output logic            reg_wr_stb,
   output logic            reg_rd_stb,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   // Frame events
   output logic            frame_done,
   output logic            frame_clk_count_bad,
   output logic            primary_fault_read
);
   // Idle at time zero
   initial begin
      {reg_wr_stb, reg_rd_stb, frame_done, frame_clk_count_bad, primary_fault_read} = '0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // One access held over one rising edge; released lines show inverted garbage
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                         input logic bad, output logic [7:0] rdata);
      @(negedge ref_clk);
      reg_wr_stb = wr;
      reg_rd_stb = ~wr;
      reg_addr = addr;
      reg_wdata = data;
      frame_clk_count_bad = bad;
      @(negedge ref_clk);
      rdata = reg_rdata;
      reg_wr_stb = 1'b0;
      reg_rd_stb = 1'b0;
      reg_addr = ~addr;
      reg_wdata = ~data;
      frame_clk_count_bad = 1'b0;
   endtask
   // One-cycle frame end or primary fault read event
   task automatic pulse(input logic done, input logic bad, input logic pfr);
      @(negedge ref_clk);
      frame_done = done;
      frame_clk_count_bad = bad;
      primary_fault_read = pfr;
      @(negedge ref_clk);
      {frame_done, frame_clk_count_bad, primary_fault_read} = '0;
   endtask
endmodule

// File: testbench.sv
// Self-checking testbench for the input configuration and secondary fault register bank
`timescale 1ns/1ns
module testbench;
   logic       ref_clk, reset, wbe, led_off, freeze, shen, slow, smiss, summ;
   logic       wr_stb, rd_stb, fdone, fbad, pfr;
   logic [7:0] addr, wdata, rdata, fstate, ien, csrc, istate, rd;
   logic [6:0] det_v;                       // Ref faults 0..3, overtemp 4, supply 5..6
   logic [1:0] mode;
   logic [3:0] sc [6] = '{4'h0, 4'he, 4'h5, 4'h2, 4'hc, 4'h7}; // {cfg4, keeps, mode}
   int         num_errors = 0;
   int         n_tests = 0;

   input_cfg_regs u_input_cfg_regs (.ref_clk(ref_clk), .reset(reset), .reg_wr_stb(wr_stb),
      .reg_rd_stb(rd_stb), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .frame_done(fdone), .frame_clk_count_bad(fbad), .primary_fault_read(pfr),
      .spi_mode(mode), .wirebreak_any_enabled(wbe), .supply_low_det(det_v[5]),
      .supply_missing_det(det_v[6]), .overtemp_det(det_v[4]), .input_ref_open_det(det_v[3]),
      .input_ref_short_det(det_v[2]), .wirebreak_ref_open_det(det_v[1]),
      .wirebreak_ref_short_det(det_v[0]), .filtered_state(fstate), .input_enable(ien),
      .current_source_on(csrc), .led_drivers_off(led_off), .filter_freeze(freeze),
      .input_ref_short_detect_enable(shen), .input_state_register(istate),
      .supply_low_flag(slow), .supply_missing_flag(smiss), .secondary_fault_summary(summ));
   host_model u_host_model (.ref_clk(ref_clk), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .frame_done(fdone),
      .frame_clk_count_bad(fbad), .primary_fault_read(pfr));

   // 50 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host_model.access(1'b1, a, d, 1'b0, rd);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      u_host_model.access(1'b0, a, 8'h00, 1'b0, rd);
      check(rd, exp);
   endtask
   // Detector levels need the synchroniser plus one register edge
   task automatic hold(input logic [6:0] v);
      det_v = v;
      repeat (5) @(negedge ref_clk);
   endtask
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      #400000;
      num_errors++;
      stop_test();
   end

   initial begin
      {det_v, mode, wbe, reset, fstate} = {7'h00, 2'h0, 1'b0, 1'b1, 8'hff};
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      wbe = 1'b1;
      // Reset values in offset order: config, enables, status, enable mask, unmapped
      for (int i = 0; i < 5; i++) begin
         rdc(8'h18 + 8'(2 * i), 8'(40'h00ff020000 >> (8 * (4 - i))));
      end
      rdc(8'h1c, 8'h00);
      wbe = 1'b0;
      repeat (3) @(negedge ref_clk);
      wbe = 1'b1;
      rdc(8'h1c, 8'h02);
      rdc(8'h1c, 8'h00);
      // Config fields, reserved bits and the freeze release
      wr(8'h18, 8'hff);
      @(negedge ref_clk);
      check(8'({freeze, shen}), 8'h03);
      rdc(8'h18, 8'h19);
      wr(8'h18, 8'h00);
      @(negedge ref_clk);
      check(8'({freeze, shen}), 8'h00);
      wr(8'h1e, 8'hff);
      rdc(8'h1e, 8'h3f);
      wr(8'h1e, 8'h00);
      wr(8'h1a, 8'h5a);
      @(negedge ref_clk);
      check(ien & csrc & istate, 8'h5a);
      check(ien | csrc | istate, 8'h5a);
      wr(8'h1a, 8'hff);
      // Reference pin faults latch until read; only the detected short kills inputs
      wr(8'h18, 8'h01);
      for (int i = 0; i < 4; i++) begin
         hold(7'(1 << i));
         check(ien, (i == 2) ? 8'h00 : 8'hff);
         hold(7'h00);
         check(ien, 8'hff);
         rdc(8'h1c, 8'(1 << i));
         rdc(8'h1c, 8'h00);
      end
      hold(7'h10);
      check(8'(led_off), 8'h01);
      check(ien | csrc, 8'h00);
      hold(7'h00);
      rdc(8'h1c, 8'h1a);
      // Clock count error, masking and summary clearing
      wr(8'h1e, 8'h1f);
      u_host_model.pulse(1'b1, 1'b1, 1'b0);
      @(negedge ref_clk);
      check(8'(summ), 8'h00);
      // Frame-end path alone sets the count error; read clears it for the write path
      rdc(8'h1c, 8'h20);
      u_host_model.access(1'b1, 8'h1a, 8'h00, 1'b1, rd);
      rdc(8'h1a, 8'hff);
      wr(8'h1e, 8'h20);
      @(negedge ref_clk);
      check(8'(summ), 8'h01);
      u_host_model.pulse(1'b0, 1'b0, 1'b1);
      check(8'(summ), 8'h01);
      rdc(8'h1c, 8'h20);
      u_host_model.pulse(1'b0, 1'b0, 1'b1);
      check(8'(summ), 8'h00);
      // Supply flags across clear modes and interface modes
      for (int i = 0; i < 6; i++) begin
         wr(8'h18, {3'h0, sc[i][3], 4'h0});
         mode = sc[i][1:0];
         hold(7'h60);
         hold(7'h00);
         check(8'({smiss, slow}), 8'h03);
         u_host_model.pulse(1'b1, 1'b0, 1'b0);
         check(8'({smiss, slow}), sc[i][2] ? 8'h03 : 8'h00);
         u_host_model.pulse(1'b0, 1'b0, 1'b1);
         check(8'({smiss, slow}), 8'h00);
      end
      stop_test();
   end
endmodule
